/* File: rtl/lpddr_cfg.svh */
`ifndef LPDDR_CFG_SVH
`define LPDDR_CFG_SVH

// ----------------------------------------
// link geometry
// ----------------------------------------
`define ADDR_W 14
`define DQ_W 16
`define LANES 2
`define BANKS 4
`define COL_W 10
`define AP_BIT 10
`define BURST_LEN 4'h4
`define MEM_WORDS 64
`define STATUS_BANK 2'h3

// ----------------------------------------
// timing, 10 MHz clock
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define T_MRD_NS 200
`define T_RP_NS 300
`define T_RFC_NS 800
`define T_WR_NS 200
`define CYCLES(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRD_CYC `CYCLES(`T_MRD_NS)
`define RP_CYC `CYCLES(`T_RP_NS)
`define RFC_CYC `CYCLES(`T_RFC_NS)
`define WR_CYC `CYCLES(`T_WR_NS)

// ----------------------------------------
// controller register map and fields
// ----------------------------------------
`define REG_CMD 4'h0
`define REG_ADDR 4'h1
`define REG_MASK 4'h2
`define REG_STATUS 4'h3
`define REG_WBUF_HI 2'h2
`define REG_RBUF_HI 2'h3
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 4
`define CMD_AP_BIT 6
`define ST_ERR_BIT 7

`endif

/* File: rtl/lpddr_pkg.sv */
`include "lpddr_cfg.svh"

package lpddr_pkg;

  // {ras_n, cas_n, we_n} with the chip selected
  typedef enum logic [2:0] {
    cmd_no_operation = 3'b111,
    cmd_activate = 3'b011,
    cmd_read = 3'b101,
    cmd_write = 3'b100,
    cmd_terminate = 3'b110,
    cmd_precharge = 3'b010,
    cmd_refresh = 3'b001,
    cmd_mode_load = 3'b000
  } cmd_type;

  typedef enum logic [1:0] {
    pwr_on = 2'b00,
    pwr_self_refresh = 2'b01,
    pwr_deep_power_down = 2'b10
  } pwr_type;

  typedef enum logic [3:0] {
    op_activate = 4'b0000,
    op_read = 4'b0001,
    op_write = 4'b0010,
    op_precharge = 4'b0011,
    op_terminate = 4'b0100,
    op_refresh = 4'b0101,
    op_mode_load = 4'b0110,
    op_self_refresh = 4'b0111,
    op_deep_power_down = 4'b1000,
    op_wake = 4'b1001
  } op_type;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_write = 3'b001,
    st_read = 3'b010,
    st_wait = 3'b011,
    st_sleep = 3'b100,
    st_wake = 3'b101
  } ctrl_state_type;

  typedef struct packed {
    logic [`BANKS-1:0] open;
    logic [`BANKS-1:0][`ADDR_W-1:0] row;
    logic [3:0] burst_left;
    logic burst_wr;
    logic burst_ap;
    logic [1:0] burst_bank;
    logic [`COL_W-1:0] burst_col;
    pwr_type pwr;
    logic [`ADDR_W-1:0] ref_row;
    logic [3:0] ref_busy;
    logic [2:0][`ADDR_W-1:0] mode;
    logic [`DQ_W-1:0] rdata;
    logic rvalid;
  } mem_state_type;

  typedef struct packed {
    ctrl_state_type st;
    logic [3:0] timer;
    logic [1:0] beat;
    logic self_ref;
    logic rd_ap;
    logic [1:0] acc_bank;
    logic [`BANKS-1:0] open;
    logic err;
    logic [`ADDR_W-1:0] addr_reg;
    logic [`LANES-1:0] mask_reg;
    logic [3:0][`DQ_W-1:0] wbuf;
    logic [3:0][`DQ_W-1:0] rbuf;
    logic [`DQ_W-1:0] sw_rdata;
    logic cs_n;
    logic [2:0] cmd;
    logic cke;
    logic [1:0] ba;
    logic [`ADDR_W-1:0] addr;
    logic [`DQ_W-1:0] dq;
    logic [`LANES-1:0] dm;
  } ctrl_state_type_all_type;

endpackage

/* File: rtl/lpddr_link_if.sv */
`timescale 1ns/1ns
`include "lpddr_cfg.svh"

interface lpddr_link_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [1:0] bank_select;
  logic [`ADDR_W-1:0] addr;
  logic [`DQ_W-1:0] dq_wr;
  logic [`LANES-1:0] write_mask;
  logic [`DQ_W-1:0] dq_rd;
  logic rd_valid;

  modport mem_end (
    input cs_n, ras_n, cas_n, we_n, cke, bank_select, addr, dq_wr, write_mask,
    output dq_rd, rd_valid
  );
  modport ctrl_end (
    output cs_n, ras_n, cas_n, we_n, cke, bank_select, addr, dq_wr, write_mask,
    input dq_rd, rd_valid
  );
endinterface

/* File: rtl/lpddr_memory.sv */
`timescale 1ns/1ns
`include "lpddr_cfg.svh"

// Notes on behaviour
// - decode select and three strobes each edge
// - controller keeps clock_enable high except in reset and from sleep entry to wake
// - deselect and no_operation change nothing
// - activate opens addressed row in selected bank
// - controller precharges before opening another row
// - access takes bank, column, per-command auto precharge
// - auto precharge closes row at burst end
// - masked-low bytes written, masked-high bytes ignored
// - mode load only all idle, then wait
// - mode load picks register by bank_select
// - precharge one bank, or all with bit
// - controller waits precharge_time, reactivates before access
// - terminate truncates latest read, page stays open
// - terminate only for reads without auto precharge
// - terminate code with clock_enable low: deep_power_down
// - refresh code with clock_enable low: self refresh
// - refresh uses internal row counter, busy refresh_cycle_time
// - controller issues every refresh separately
// - self refresh ignores all but clock_enable
// - controller refreshes right after self refresh exit
// - deep_power_down loses array contents
// - controller finishes bursts before stopping the link
module lpddr_memory (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  lpddr_link_if.mem_end link,
  output logic [`BANKS-1:0] bank_open,
  output lpddr_pkg::pwr_type power_state,
  output logic [`ADDR_W-1:0] refresh_row,
  output logic [`ADDR_W-1:0] mode_std,
  output logic [`ADDR_W-1:0] mode_ext,
  output logic [`ADDR_W-1:0] mode_status
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  lpddr_pkg::mem_state_type q;
  lpddr_pkg::mem_state_type d;
  lpddr_pkg::cmd_type cmd;
  logic [`DQ_W-1:0] mem [`MEM_WORDS];
  logic [5:0] mem_idx;
  logic [`LANES-1:0] mem_be;
  logic mem_clear;

  assign cmd = lpddr_pkg::cmd_type'({link.ras_n, link.cas_n, link.we_n});
  // small array: one row bit and three column bits per bank are kept
  assign mem_idx = {q.burst_bank, q.row[q.burst_bank][0], q.burst_col[2:0]};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    mem_be = '0;
    mem_clear = 1'b0;
    if (q.burst_left != 4'h0) begin
      if (q.burst_wr) begin
        mem_be = ~link.write_mask;
      end else begin
        d.rdata = mem[mem_idx];
        d.rvalid = 1'b1;
      end
      d.burst_col = q.burst_col + `COL_W'(1);
      d.burst_left = q.burst_left - 4'h1;
      if (q.burst_left == 4'h1 && q.burst_ap) begin
        d.open[q.burst_bank] = 1'b0;
      end
    end
    if (q.ref_busy != 4'h0) begin
      d.ref_busy = q.ref_busy - 4'h1;
    end
    unique case (q.pwr)
      lpddr_pkg::pwr_self_refresh: begin
        // every pin but clock_enable is ignored here
        if (link.cke) begin
          d.pwr = lpddr_pkg::pwr_on;
        end
      end
      lpddr_pkg::pwr_deep_power_down: begin
        if (link.cke) begin
          d.pwr = lpddr_pkg::pwr_on;
        end
      end
      lpddr_pkg::pwr_on: begin
        // refresh period admits no executable command
        if (!link.cs_n && q.ref_busy == 4'h0) begin
          unique case (cmd)
            lpddr_pkg::cmd_no_operation: begin
              d.open = q.open;
            end
            lpddr_pkg::cmd_activate: begin
              d.open[link.bank_select] = 1'b1;
              d.row[link.bank_select] = link.addr;
            end
            lpddr_pkg::cmd_read,
            lpddr_pkg::cmd_write: begin
              d.burst_bank = link.bank_select;
              d.burst_col = link.addr[`COL_W-1:0];
              d.burst_ap = link.addr[`AP_BIT];
              d.burst_wr = (cmd == lpddr_pkg::cmd_write);
              d.burst_left = `BURST_LEN;
            end
            lpddr_pkg::cmd_terminate: begin
              if (!link.cke) begin
                d.pwr = lpddr_pkg::pwr_deep_power_down;
                d.open = '0;
                d.burst_left = 4'h0;
                mem_clear = 1'b1;
              end else if (!q.burst_wr && !q.burst_ap) begin
                d.burst_left = 4'h0;
              end
            end
            lpddr_pkg::cmd_precharge: begin
              if (link.addr[`AP_BIT]) begin
                d.open = '0;
              end else begin
                d.open[link.bank_select] = 1'b0;
              end
            end
            lpddr_pkg::cmd_refresh: begin
              if (!link.cke) begin
                d.pwr = lpddr_pkg::pwr_self_refresh;
              end else begin
                d.ref_row = q.ref_row + `ADDR_W'(1);
                d.ref_busy = 4'(`RFC_CYC);
              end
            end
            lpddr_pkg::cmd_mode_load: begin
              if (link.bank_select != `STATUS_BANK) begin
                d.mode[link.bank_select] = link.addr;
              end
            end
          endcase
        end
      end
      default: begin
        d.pwr = lpddr_pkg::pwr_on;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // array has no reset: contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mem_clear) begin
        for (int i = 0; i < `MEM_WORDS; i++) begin
          mem[i] <= '0;
        end
      end else begin
        for (int b = 0; b < `LANES; b++) begin
          if (mem_be[b]) begin
            mem[mem_idx][b*8 +: 8] <= link.dq_wr[b*8 +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.dq_rd = q.rdata;
  assign link.rd_valid = q.rvalid;
  assign bank_open = q.open;
  assign power_state = q.pwr;
  assign refresh_row = q.ref_row;
  assign mode_std = q.mode[0];
  assign mode_ext = q.mode[1];
  assign mode_status = q.mode[2];

endmodule

/* File: rtl/lpddr_controller.sv */
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "lpddr_cfg.svh"

module lpddr_controller (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] sw_addr,
  input wire logic [`DQ_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [`DQ_W-1:0] sw_rdata,
  lpddr_link_if.ctrl_end link
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  lpddr_pkg::ctrl_state_type_all_type q;
  lpddr_pkg::ctrl_state_type_all_type d;
  lpddr_pkg::op_type op;
  logic [1:0] ba;
  logic ap;
  logic go;
  logic bad;

  assign op = lpddr_pkg::op_type'(sw_wdata[`CMD_OP_LSB +: 4]);
  assign ba = sw_wdata[`CMD_BANK_LSB +: 2];
  assign ap = sw_wdata[`CMD_AP_BIT];
  assign go = sw_wr && sw_addr == `REG_CMD;

  task automatic issue(input lpddr_pkg::cmd_type c, input logic ck);
    d.cs_n = 1'b0;
    d.cmd = c;
    d.cke = ck;
  endtask

  always_comb begin
    d = q;
    bad = 1'b0;
    d.cs_n = 1'b1;
    d.cmd = lpddr_pkg::cmd_no_operation;
    // ----------------------------------------
    // register port
    // ----------------------------------------
    if (sw_rd) begin
      unique case (sw_addr[3:2])
        `REG_WBUF_HI: d.sw_rdata = q.wbuf[sw_addr[1:0]];
        `REG_RBUF_HI: d.sw_rdata = q.rbuf[sw_addr[1:0]];
        default: begin
          unique case (sw_addr)
            `REG_ADDR: d.sw_rdata = `DQ_W'(q.addr_reg);
            `REG_MASK: d.sw_rdata = `DQ_W'(q.mask_reg);
            `REG_STATUS: d.sw_rdata = {8'h00, q.err, q.st == lpddr_pkg::st_sleep,
              q.st != lpddr_pkg::st_idle, 1'b0, q.open};
            default: d.sw_rdata = '0;
          endcase
        end
      endcase
    end
    if (sw_wr) begin
      unique case (sw_addr[3:2])
        `REG_WBUF_HI: d.wbuf[sw_addr[1:0]] = sw_wdata;
        `REG_RBUF_HI: d.err = q.err;
        default: begin
          unique case (sw_addr)
            `REG_ADDR: d.addr_reg = sw_wdata[`ADDR_W-1:0];
            `REG_MASK: d.mask_reg = sw_wdata[`LANES-1:0];
            `REG_STATUS: d.err = q.err & ~sw_wdata[`ST_ERR_BIT];
            default: d.err = q.err;
          endcase
        end
      endcase
    end
    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    if (q.timer != 4'h0) begin
      d.timer = q.timer - 4'h1;
    end
    unique case (q.st)
      lpddr_pkg::st_idle: begin
        d.cke = 1'b1;
        if (go) begin
          d.ba = ba;
          d.addr = q.addr_reg;
          d.acc_bank = ba;
          d.beat = 2'h0;
          unique case (op)
            lpddr_pkg::op_activate: begin
              if (q.open[ba]) begin
                bad = 1'b1;
              end else begin
                issue(lpddr_pkg::cmd_activate, 1'b1);
                d.open[ba] = 1'b1;
              end
            end
            lpddr_pkg::op_read,
            lpddr_pkg::op_write: begin
              if (!q.open[ba]) begin
                bad = 1'b1;
              end else begin
                d.addr[`AP_BIT] = ap;
                d.rd_ap = ap;
                if (op == lpddr_pkg::op_read) begin
                  issue(lpddr_pkg::cmd_read, 1'b1);
                  d.st = lpddr_pkg::st_read;
                end else begin
                  issue(lpddr_pkg::cmd_write, 1'b1);
                  d.st = lpddr_pkg::st_write;
                end
              end
            end
            lpddr_pkg::op_precharge: begin
              issue(lpddr_pkg::cmd_precharge, 1'b1);
              d.addr[`AP_BIT] = ap;
              if (ap) begin
                d.open = '0;
              end else begin
                d.open[ba] = 1'b0;
              end
              d.timer = 4'(`RP_CYC);
              d.st = lpddr_pkg::st_wait;
            end
            lpddr_pkg::op_refresh,
            lpddr_pkg::op_mode_load,
            lpddr_pkg::op_self_refresh,
            lpddr_pkg::op_deep_power_down: begin
              // all these need every bank idle
              if (q.open != '0) begin
                bad = 1'b1;
              end else if (op == lpddr_pkg::op_refresh) begin
                issue(lpddr_pkg::cmd_refresh, 1'b1);
                d.timer = 4'(`RFC_CYC);
                d.st = lpddr_pkg::st_wait;
              end else if (op == lpddr_pkg::op_mode_load) begin
                issue(lpddr_pkg::cmd_mode_load, 1'b1);
                d.timer = 4'(`MRD_CYC);
                d.st = lpddr_pkg::st_wait;
              end else begin
                // only reached with no burst running
                d.self_ref = (op == lpddr_pkg::op_self_refresh);
                issue(d.self_ref ? lpddr_pkg::cmd_refresh : lpddr_pkg::cmd_terminate,
                  1'b0);
                d.st = lpddr_pkg::st_sleep;
              end
            end
            default: bad = 1'b1;
          endcase
        end
      end
      lpddr_pkg::st_write: begin
        d.dq = q.wbuf[q.beat];
        d.dm = q.mask_reg;
        d.beat = q.beat + 2'h1;
        if (q.beat == 2'(`BURST_LEN - 4'h1)) begin
          if (q.rd_ap) begin
            d.open[q.acc_bank] = 1'b0;
          end
          d.timer = 4'(`WR_CYC) + (q.rd_ap ? 4'(`RP_CYC) : 4'h0);
          d.st = lpddr_pkg::st_wait;
        end
        bad = go;
      end
      lpddr_pkg::st_read: begin
        if (link.rd_valid) begin
          d.rbuf[q.beat] = link.dq_rd;
          d.beat = q.beat + 2'h1;
          if (q.beat == 2'(`BURST_LEN - 4'h1)) begin
            if (q.rd_ap) begin
              d.open[q.acc_bank] = 1'b0;
            end
            d.timer = q.rd_ap ? 4'(`RP_CYC) : 4'h0;
            d.st = lpddr_pkg::st_wait;
          end
        end
        if (go) begin
          // truncating an auto-precharge read is undefined at the far end
          if (op == lpddr_pkg::op_terminate && !q.rd_ap) begin
            issue(lpddr_pkg::cmd_terminate, 1'b1);
            d.st = lpddr_pkg::st_idle;
          end else begin
            bad = 1'b1;
          end
        end
      end
      lpddr_pkg::st_wait: begin
        if (q.timer <= 4'h1) begin
          d.st = lpddr_pkg::st_idle;
        end
        bad = go;
      end
      lpddr_pkg::st_sleep: begin
        d.cke = 1'b0;
        if (go) begin
          if (op == lpddr_pkg::op_wake) begin
            d.cke = 1'b1;
            d.open = '0;
            d.st = q.self_ref ? lpddr_pkg::st_wake : lpddr_pkg::st_idle;
          end else begin
            bad = 1'b1;
          end
        end
      end
      lpddr_pkg::st_wake: begin
        issue(lpddr_pkg::cmd_refresh, 1'b1);
        d.timer = 4'(`RFC_CYC);
        d.st = lpddr_pkg::st_wait;
        bad = go;
      end
      default: d.st = lpddr_pkg::st_idle;
    endcase
    if (bad) begin
      d.err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.cmd <= lpddr_pkg::cmd_no_operation;
      q.mask_reg <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign sw_rdata = q.sw_rdata;
  assign link.cs_n = q.cs_n;
  assign link.ras_n = q.cmd[2];
  assign link.cas_n = q.cmd[1];
  assign link.we_n = q.cmd[0];
  assign link.cke = q.cke;
  assign link.bank_select = q.ba;
  assign link.addr = q.addr;
  assign link.dq_wr = q.dq;
  assign link.write_mask = q.dm;

endmodule

/* File: test/lpddr_link_checker.sv */
`timescale 1ns/1ns
`include "lpddr_cfg.svh"

module lpddr_link_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [1:0] bank_select,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DQ_W-1:0] dq_wr,
  input wire logic [`LANES-1:0] write_mask,
  input wire logic [`DQ_W-1:0] dq_rd,
  input wire logic rd_valid
);
  // ----------------------------------------
  // read tracking
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] since_rd;
    logic [2:0] beats;
  } mon_type;
  mon_type mon_q;
  mon_type mon_d;
  logic [2:0] cmd;
  logic sel;
  logic exec;
  assign cmd = {ras_n, cas_n, we_n};
  assign sel = !cs_n;
  assign exec = sel && (cmd != lpddr_pkg::cmd_no_operation);

  always_comb begin
    mon_d = mon_q;
    if (mon_q.since_rd != 4'hf) begin
      mon_d.since_rd = mon_q.since_rd + 4'h1;
    end
    if (rd_valid) begin
      mon_d.beats = mon_q.beats + 3'h1;
    end
    // saturating age so a late beat is never excused by wrap-around
    if (sel && cke && cmd == lpddr_pkg::cmd_read) begin
      mon_d.since_rd = 4'h0;
      mon_d.beats = 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_q <= '{since_rd: 4'hf, beats: 3'h0};
    end else begin
      mon_q <= mon_d;
    end
  end

  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read;
    sel && cke && cmd == lpddr_pkg::cmd_read;
  endsequence
  sequence s_quiet;
    !(sel && cmd == lpddr_pkg::cmd_terminate);
  endsequence

  a_first_beat: assert property (s_read ##1 s_quiet ##1 s_quiet |-> rd_valid)
    else $error("first read beat late");
  a_full_burst: assert property (s_read ##1 s_quiet [*4] |-> rd_valid ##1 rd_valid ##1 !rd_valid)
    else $error("read burst not four beats");
  a_beat_window: assert property (rd_valid |-> mon_q.since_rd inside {[1:4]})
    else $error("read beat outside burst window");
  a_burst_len: assert property (rd_valid |-> mon_q.beats < 3'h4)
    else $error("too many read beats");
  a_cke_entry: assert property ($fell(cke) |-> sel && (cmd == lpddr_pkg::cmd_refresh
      || cmd == lpddr_pkg::cmd_terminate))
    else $error("clock enable dropped outside sleep entry");
  a_cke_burst: assert property ($fell(cke) |-> mon_q.since_rd > 4'h5)
    else $error("clock enable dropped during burst");
  a_asleep_quiet: assert property (!cke && $past(!cke) |-> !rd_valid)
    else $error("read data while asleep");
  a_mode_gap: assert property (sel && cke && cmd == lpddr_pkg::cmd_mode_load |=> !exec)
    else $error("command too soon after mode load");
  a_refresh_gap: assert property (sel && cke && cmd == lpddr_pkg::cmd_refresh
      |=> !exec [*7])
    else $error("command during refresh");
  a_precharge_gap: assert property (sel && cke && cmd == lpddr_pkg::cmd_precharge
      |=> !(sel && cmd == lpddr_pkg::cmd_activate) [*2])
    else $error("activate too soon after precharge");
  a_term_read: assert property (sel && cke && cmd == lpddr_pkg::cmd_terminate
      |-> mon_q.since_rd <= 4'h8)
    else $error("terminate without recent read");
endmodule

/* File: test/lpddr_command_decoder_test.sv */
`timescale 1ns/1ns
`include "lpddr_cfg.svh"

module lpddr_command_decoder_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [`DQ_W-1:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [`DQ_W-1:0] sw_rdata;
  logic [`BANKS-1:0] bank_open;
  lpddr_pkg::pwr_type power_state;
  logic [`ADDR_W-1:0] refresh_row;
  logic [`ADDR_W-1:0] mode_std;
  logic [`ADDR_W-1:0] mode_ext;
  logic [`ADDR_W-1:0] mode_status;
  logic [`DQ_W-1:0] exp_q [4];
  int err_count = 0;
  int checks = 0;

  always #50 ref_clk = ~ref_clk;

  lpddr_link_if u_lpddr_link_if ();
  lpddr_memory u_lpddr_memory (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .link(u_lpddr_link_if.mem_end), .bank_open(bank_open), .power_state(power_state),
    .refresh_row(refresh_row), .mode_std(mode_std), .mode_ext(mode_ext),
    .mode_status(mode_status));
  lpddr_controller u_lpddr_controller (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .link(u_lpddr_link_if.ctrl_end));
  lpddr_link_checker u_lpddr_link_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .cs_n(u_lpddr_link_if.cs_n), .ras_n(u_lpddr_link_if.ras_n),
    .cas_n(u_lpddr_link_if.cas_n), .we_n(u_lpddr_link_if.we_n), .cke(u_lpddr_link_if.cke),
    .bank_select(u_lpddr_link_if.bank_select), .addr(u_lpddr_link_if.addr),
    .dq_wr(u_lpddr_link_if.dq_wr), .write_mask(u_lpddr_link_if.write_mask),
    .dq_rd(u_lpddr_link_if.dq_rd), .rd_valid(u_lpddr_link_if.rd_valid));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_open(input logic [3:0] e);
    chk("bank_open", {12'h000, e}, {12'h000, bank_open});
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
    @(posedge ref_clk);
  endtask

  // bounded poll; a hang ends the run through the closing report
  task automatic wait_bit(input int idx, input logic val);
    logic [15:0] s;
    s = ~{16{val}};
    for (int i = 0; i < 60 && s[idx] !== val; i++) reg_rd(`REG_STATUS, s);
    if (s[idx] !== val) begin
      err_count++;
      $display("mismatch status_bit_%0d expected %b seen %b", idx, val, s[idx]);
      report_and_stop();
    end
  endtask

  task automatic op(input logic [3:0] code, input logic [1:0] bank, input logic ap);
    reg_wr(`REG_CMD, {9'h000, ap, bank, code});
    wait_bit(5, 1'b0);
  endtask

  task automatic burst_check(input logic [1:0] bank, input logic ap, input string name);
    logic [15:0] d;
    op(4'h1, bank, ap);
    for (int i = 0; i < 4; i++) begin
      reg_rd(4'hc + 4'(i), d);
      chk(name, exp_q[i], d);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_mode();
    chk_open(4'h0);
    reg_wr(`REG_ADDR, 16'h0033);
    op(4'h6, 2'h0, 1'b0);
    reg_wr(`REG_ADDR, 16'h0212);
    op(4'h6, 2'h1, 1'b0);
    reg_wr(`REG_ADDR, 16'h0101);
    op(4'h6, 2'h2, 1'b0);
    // bank 3 load must leave every mode register alone
    reg_wr(`REG_ADDR, 16'h0fff);
    op(4'h6, 2'h3, 1'b0);
    chk("mode_status", 16'h0101, {2'b00, mode_status});
    chk("mode_std", 16'h0033, {2'b00, mode_std});
    chk("mode_ext", 16'h0212, {2'b00, mode_ext});
  endtask

  task automatic t_write_mask();
    reg_wr(`REG_ADDR, 16'h0005);
    op(4'h0, 2'h2, 1'b0);
    chk_open(4'h4);
    for (int i = 0; i < 4; i++) reg_wr(4'h8 + 4'(i), {8'ha0 + 8'(i), 8'h50 + 8'(i)});
    reg_wr(`REG_MASK, 16'h0000);
    reg_wr(`REG_ADDR, 16'h0000);
    op(4'h2, 2'h2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      reg_wr(4'h8 + 4'(i), {8'hc0 + 8'(i), 8'h70 + 8'(i)});
      exp_q[i] = {8'ha0 + 8'(i), 8'h70 + 8'(i)};
    end
    reg_wr(`REG_MASK, 16'h0002);
    op(4'h2, 2'h2, 1'b0);
    burst_check(2'h2, 1'b0, "masked_word");
    chk_open(4'h4);
    burst_check(2'h2, 1'b1, "ap_word");
    chk_open(4'h0);
  endtask

  task automatic t_terminate();
    logic [15:0] s;
    reg_wr(`REG_ADDR, 16'h0005);
    op(4'h0, 2'h1, 1'b0);
    op(4'h0, 2'h1, 1'b0);
    reg_rd(`REG_STATUS, s);
    chk("status_err", 16'h0001, {15'h0000, s[7]});
    reg_wr(`REG_STATUS, 16'h0080);
    reg_rd(`REG_STATUS, s);
    chk("status_err", 16'h0000, {15'h0000, s[7]});
    reg_wr(`REG_CMD, 16'h0011);
    reg_wr(`REG_CMD, 16'h0014);
    wait_bit(5, 1'b0);
    chk_open(4'h2);
    reg_rd(`REG_STATUS, s);
    chk("status_err", 16'h0000, {15'h0000, s[7]});
  endtask

  task automatic t_precharge();
    logic [15:0] s;
    op(4'h0, 2'h0, 1'b0);
    chk_open(4'h3);
    op(4'h3, 2'h0, 1'b0);
    chk_open(4'h2);
    op(4'h0, 2'h3, 1'b0);
    chk_open(4'ha);
    op(4'h3, 2'h2, 1'b1);
    chk_open(4'h0);
    // frozen by clk_en: the activate order must be lost
    clk_en <= 1'b0;
    reg_wr(`REG_CMD, 16'h0010);
    clk_en <= 1'b1;
    reg_rd(`REG_STATUS, s);
    chk("status_open", 16'h0000, {12'h000, s[3:0]});
    chk_open(4'h0);
  endtask

  task automatic t_refresh();
    logic [`ADDR_W-1:0] r;
    r = refresh_row;
    reg_wr(`REG_ADDR, 16'h3fff);
    op(4'h5, 2'h0, 1'b0);
    op(4'h5, 2'h3, 1'b0);
    chk("refresh_row", {2'b00, r + 14'h0002}, {2'b00, refresh_row});
  endtask

  task automatic t_sleep();
    reg_wr(`REG_CMD, 16'h0007);
    wait_bit(6, 1'b1);
    chk("power_state", {14'h0000, lpddr_pkg::pwr_self_refresh}, {14'h0000, power_state});
    chk("cke", 16'h0000, {15'h0000, u_lpddr_link_if.cke});
    reg_wr(`REG_CMD, 16'h0009);
    wait_bit(6, 1'b0);
    wait_bit(5, 1'b0);
    chk("power_state", {14'h0000, lpddr_pkg::pwr_on}, {14'h0000, power_state});
    reg_wr(`REG_ADDR, 16'h0005);
    op(4'h0, 2'h2, 1'b0);
    reg_wr(`REG_ADDR, 16'h0000);
    burst_check(2'h2, 1'b1, "retained_word");
    reg_wr(`REG_CMD, 16'h0008);
    wait_bit(6, 1'b1);
    chk("power_state", {14'h0000, lpddr_pkg::pwr_deep_power_down}, {14'h0000, power_state});
    reg_wr(`REG_CMD, 16'h0009);
    wait_bit(6, 1'b0);
    wait_bit(5, 1'b0);
    for (int i = 0; i < 4; i++) exp_q[i] = 16'h0000;
    op(4'h0, 2'h2, 1'b0);
    burst_check(2'h2, 1'b1, "powered_down_word");
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_mode();
    t_write_mask();
    t_terminate();
    t_precharge();
    t_refresh();
    t_sleep();
    report_and_stop();
  end
endmodule
